// *** core/wdc_pkg.sv ***
package wdc_pkg;
  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int WG_PULSE_US   = 100;
  localparam int WG_PERIOD_US  = 1000;
  localparam int DC_THIRD_US   = 330;
  localparam logic [15:0] WG_PULSE_CYC  = 16'(WG_PULSE_US * CLK_MHZ);
  localparam logic [15:0] WG_PERIOD_CYC = 16'(WG_PERIOD_US * CLK_MHZ);
  localparam logic [15:0] DC_THIRD_CYC  = 16'(DC_THIRD_US * CLK_MHZ);

  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_DATA   = 8'h04;
  localparam logic [7:0] A_PULSE  = 8'h08;
  localparam logic [7:0] A_CLKOUT = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_XLAT  = 2;
  localparam int CTRL_RAW   = 7;
  localparam int CTRL_LEN   = 8;

  // ***********************************************
  // framing
  // ***********************************************
  localparam logic [3:0] DIG_START = 4'hb;
  localparam logic [3:0] DIG_SEP   = 4'hd;
  localparam logic [3:0] DIG_STOP  = 4'hf;
  localparam logic [3:0] DIG_TEN   = 4'ha;
  localparam logic [5:0] EDGE_BITS = 6'h10;
  localparam logic [5:0] DIG_BITS  = 6'h05;
  localparam logic       MODE_WG   = 1'b0;
  localparam logic       MODE_DC   = 1'b1;

  typedef struct packed {
    logic [5:0] len;
    logic       raw;
    logic [1:0] xlat;
    logic       mode;
  } wdc_ctrl_t;

  localparam wdc_ctrl_t CTRL_RST = '{len: 6'h00, raw: 1'b0,
                                     xlat: 2'h0, mode: MODE_WG};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_START = 3'b011,
    ST_BODY  = 3'b010,
    ST_STOP  = 3'b110,
    ST_CHECK = 3'b111,
    ST_TRAIL = 3'b101,
    ST_DRAIN = 3'b100
  } wdc_state_t;
endpackage

// *** core/wdc_top.sv ***
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wdc_top #(
  parameter logic [15:0] P_WG_PULSE  = wdc_pkg::WG_PULSE_CYC,
  parameter logic [15:0] P_WG_PERIOD = wdc_pkg::WG_PERIOD_CYC,
  parameter logic [15:0] P_DC_THIRD  = wdc_pkg::DC_THIRD_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_led_red,
  input  wire logic        i_led_green,
  output logic             o_zero_bit_line,
  output logic             o_one_bit_line,
  output logic             o_led_red_on,
  output logic             o_led_green_on
);
  // ***********************************************
  // declarations
  // ***********************************************
  wdc_pkg::wdc_ctrl_t  ctrl;
  wdc_pkg::wdc_state_t st;
  logic [31:0] data_r, dreg, sh, ld_val, rd_mux;
  logic [15:0] wg_pulse, wg_period, dc_third, pw, gap, tcnt, d0, d1;
  logic [7:0]  dp_addr;
  logic [5:0]  bits_left, ld_n;
  logic [3:0]  nib_left, chk, n, dg, d_dig;
  logic [1:0]  tph, tlast, red_s, grn_s;
  logic        dp_wr, go_q, busy, take, wg, active, ld, ld_dig;
  logic        sub, in_run, dec, d_emit, d_adv, d_sub, d_run;

  // ***********************************************
  // ahb-lite slave
  // ***********************************************
  assign take = i_hsel & i_htrans[1] & i_hready;
  assign busy = go_q | (st != wdc_pkg::ST_IDLE) | (bits_left != 6'h0);

  always_comb begin
    rd_mux = 32'h0;
    if (i_haddr[31:8] == 24'h0) begin
      case (i_haddr[7:0])
        wdc_pkg::A_CTRL:   rd_mux = {18'h0, ctrl.len, ctrl.raw, 3'h0,
                                     ctrl.xlat, ctrl.mode, 1'b0};
        wdc_pkg::A_DATA:   rd_mux = data_r;
        wdc_pkg::A_PULSE:  rd_mux = {wg_period, wg_pulse};
        wdc_pkg::A_CLKOUT: rd_mux = {16'h0, dc_third};
        wdc_pkg::A_STATUS: rd_mux = {26'h0, st, o_led_green_on,
                                     o_led_red_on, busy};
        default:           rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dp_wr       <= 1'b0;
      dp_addr     <= 8'h0;
      o_hrdata    <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      dp_wr       <= take & i_hwrite & (i_hsize == 3'h2)
                     & (i_haddr[31:8] == 24'h0);
      dp_addr     <= i_haddr[7:0];
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (take & !i_hwrite) begin
        o_hrdata <= rd_mux;
      end
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl      <= wdc_pkg::CTRL_RST;
      data_r    <= 32'h0;
      wg_pulse  <= P_WG_PULSE;
      wg_period <= P_WG_PERIOD;
      dc_third  <= P_DC_THIRD;
      go_q      <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (dp_wr) begin
        case (dp_addr)
          wdc_pkg::A_CTRL: if (!busy) begin
            ctrl.len  <= i_hwdata[wdc_pkg::CTRL_LEN +: 6];
            ctrl.raw  <= i_hwdata[wdc_pkg::CTRL_RAW];
            ctrl.xlat <= i_hwdata[wdc_pkg::CTRL_XLAT +: 2];
            ctrl.mode <= i_hwdata[wdc_pkg::CTRL_MODE];
            go_q      <= i_hwdata[wdc_pkg::CTRL_START];
          end
          wdc_pkg::A_DATA:   data_r <= i_hwdata;
          wdc_pkg::A_PULSE:  {wg_period, wg_pulse} <= i_hwdata;
          wdc_pkg::A_CLKOUT: dc_third <= i_hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ***********************************************
  // bit timing
  // ***********************************************
  assign wg     = (ctrl.mode == wdc_pkg::MODE_WG);
  assign active = (bits_left != 6'h0);
  assign pw     = (wg_pulse == 16'h0) ? P_WG_PULSE : wg_pulse;
  assign gap    = (((wg_period == 16'h0) ? P_WG_PERIOD : wg_period) > pw)
                  ? ((wg_period == 16'h0) ? P_WG_PERIOD : wg_period) - pw
                  : 16'h1;
  assign d1     = wg ? gap : ((dc_third == 16'h0) ? P_DC_THIRD : dc_third);
  assign d0     = wg ? pw : d1;
  assign tlast  = wg ? 2'h1 : 2'h2;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sh        <= 32'h0;
      bits_left <= 6'h0;
      tph       <= 2'h0;
      tcnt      <= 16'h0;
    end else if (ld) begin
      sh        <= ld_val;
      bits_left <= ld_n;
      tph       <= 2'h0;
      tcnt      <= d0 - 16'h1;
    end else if (active) begin
      if (tcnt != 16'h0) begin
        tcnt <= tcnt - 16'h1;
      end else if (tph == tlast) begin
        sh        <= sh >> 1;
        bits_left <= bits_left - 6'h1;
        tph       <= 2'h0;
        tcnt      <= d0 - 16'h1;
      end else begin
        tph  <= tph + 2'h1;
        tcnt <= d1 - 16'h1;
      end
    end
  end

  // ***********************************************
  // digit translation
  // ***********************************************
  assign n   = dreg[31:28];
  assign dec = (n < wdc_pkg::DIG_TEN);

  always_comb begin
    d_emit = 1'b1;
    d_dig  = n;
    d_adv  = 1'b1;
    d_sub  = 1'b0;
    d_run  = in_run;
    if (!ctrl.raw) begin
      case (ctrl.xlat)
        2'h0: d_emit = dec;
        2'h1: begin
          if (dec) begin
            d_run = 1'b0;
          end else begin
            d_emit = !in_run;
            d_dig  = wdc_pkg::DIG_SEP;
            d_run  = 1'b1;
          end
        end
        2'h2: begin
          if (!sub) begin
            d_dig = {3'h0, !dec};
            d_adv = 1'b0;
            d_sub = 1'b1;
          end else begin
            d_dig = dec ? n : n - wdc_pkg::DIG_TEN;
          end
        end
        default: begin
          if (!dec && !sub) begin
            d_dig = wdc_pkg::DIG_SEP;
            d_adv = 1'b0;
            d_sub = 1'b1;
          end else if (!dec) begin
            d_dig = n - wdc_pkg::DIG_TEN;
          end
        end
      endcase
    end
  end

  // ***********************************************
  // unit loader
  // ***********************************************
  always_comb begin
    ld     = 1'b0;
    ld_dig = 1'b0;
    ld_val = 32'h0;
    ld_n   = 6'h0;
    dg     = 4'h0;
    if (!active) begin
      case (st)
        wdc_pkg::ST_IDLE: if (go_q && wg) begin
          ld     = 1'b1;
          ld_n   = ctrl.len;
          ld_val = {<<{data_r}} >> (6'd32 - ctrl.len);
        end
        wdc_pkg::ST_LEAD, wdc_pkg::ST_TRAIL: begin
          ld   = 1'b1;
          ld_n = wdc_pkg::EDGE_BITS;
        end
        wdc_pkg::ST_START: begin
          ld_dig = 1'b1;
          dg     = wdc_pkg::DIG_START;
        end
        wdc_pkg::ST_BODY: begin
          ld_dig = (nib_left != 4'h0) && d_emit;
          dg     = d_dig;
        end
        wdc_pkg::ST_STOP: begin
          ld_dig = 1'b1;
          dg     = wdc_pkg::DIG_STOP;
        end
        wdc_pkg::ST_CHECK: begin
          ld_dig = 1'b1;
          dg     = chk;
        end
        default: ;
      endcase
      if (ld_dig) begin
        ld     = 1'b1;
        ld_n   = wdc_pkg::DIG_BITS;
        ld_val = {27'h0, ~^dg, dg};
      end
    end
  end

  // ***********************************************
  // frame sequencer
  // ***********************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st       <= wdc_pkg::ST_IDLE;
      dreg     <= 32'h0;
      nib_left <= 4'h0;
      sub      <= 1'b0;
      in_run   <= 1'b0;
      chk      <= 4'h0;
    end else if (!active) begin
      case (st)
        wdc_pkg::ST_IDLE: if (go_q) begin
          dreg     <= data_r << (6'd32 - {ctrl.len[3:0], 2'h0});
          nib_left <= ctrl.len[3:0];
          sub      <= 1'b0;
          in_run   <= 1'b0;
          chk      <= 4'h0;
          if (wg) begin
            st <= wdc_pkg::ST_DRAIN;
          end else if (ctrl.raw) begin
            st <= wdc_pkg::ST_BODY;
          end else begin
            st <= wdc_pkg::ST_LEAD;
          end
        end
        wdc_pkg::ST_LEAD:  st <= wdc_pkg::ST_START;
        wdc_pkg::ST_START: begin
          chk <= chk ^ wdc_pkg::DIG_START;
          st  <= wdc_pkg::ST_BODY;
        end
        wdc_pkg::ST_BODY: begin
          if (nib_left == 4'h0) begin
            st <= ctrl.raw ? wdc_pkg::ST_DRAIN : wdc_pkg::ST_STOP;
          end else begin
            if (d_emit) begin
              chk <= chk ^ d_dig;
            end
            sub    <= d_sub;
            in_run <= d_run;
            if (d_adv) begin
              dreg     <= dreg << 4;
              nib_left <= nib_left - 4'h1;
            end
          end
        end
        wdc_pkg::ST_STOP:  st <= wdc_pkg::ST_CHECK;
        wdc_pkg::ST_CHECK: st <= wdc_pkg::ST_TRAIL;
        wdc_pkg::ST_TRAIL: st <= wdc_pkg::ST_DRAIN;
        default:           st <= wdc_pkg::ST_IDLE;
      endcase
    end
  end

  // ***********************************************
  // line drivers and leds
  // ***********************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_zero_bit_line <= 1'b1;
      o_one_bit_line  <= 1'b1;
    end else if (wg) begin
      o_zero_bit_line <= !(active && tph == 2'h0 && !sh[0]);
      o_one_bit_line  <= !(active && tph == 2'h0 && sh[0]);
    end else begin
      o_zero_bit_line <= !(active && sh[0]);
      o_one_bit_line  <= !(active && tph == 2'h1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      red_s          <= 2'h3;
      grn_s          <= 2'h3;
      o_led_red_on   <= 1'b0;
      o_led_green_on <= 1'b0;
    end else begin
      red_s          <= {red_s[0], i_led_red};
      grn_s          <= {grn_s[0], i_led_green};
      o_led_red_on   <= wg ? red_s[1] : !red_s[1];
      o_led_green_on <= wg ? grn_s[1] : !grn_s[1];
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  logic [15:0] lo0, lo1;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      lo0 <= 16'h0;
      lo1 <= 16'h0;
    end else begin
      lo0 <= o_zero_bit_line ? 16'h0 : lo0 + 16'h1;
      lo1 <= o_one_bit_line ? 16'h0 : lo1 + 16'h1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  idle_lines_high_a: assert property (
    $past(!active) && $past(wg) |-> o_zero_bit_line && o_one_bit_line)
    else $error("line low while idle");
  never_both_low_a: assert property (
    wg && $past(wg) |-> o_zero_bit_line || o_one_bit_line)
    else $error("both wiegand lines low");
  zero_pulse_bit_a: assert property (
    wg && $fell(o_zero_bit_line) |-> $past(sh[0]) == 1'b0)
    else $error("zero line pulsed for a 1 bit");
  pulse_width_a: assert property (
    wg && $rose(o_zero_bit_line) |-> lo0 == pw)
    else $error("wiegand pulse width wrong");
  clock_low_third_a: assert property (
    !wg && $rose(o_one_bit_line) |-> lo1 == d1)
    else $error("dataclock low phase wrong");
  data_inverted_a: assert property (
    !wg && $past(!wg) && $past(active) |->
    o_zero_bit_line == !$past(sh[0]))
    else $error("data line not inverted");
  digit_parity_a: assert property (
    ld_dig |=> ^sh[4:0] == 1'b1)
    else $error("digit parity not odd");
  start_digit_a: assert property (
    ld && st == wdc_pkg::ST_START |=> sh[4:0] == 5'h0b)
    else $error("bad start sentinel");
  drop_nondec_a: assert property (
    ld && st == wdc_pkg::ST_BODY && !ctrl.raw && ctrl.xlat == 2'h0
    |-> dg < wdc_pkg::DIG_TEN)
    else $error("non-decimal digit sent");
  raw_no_lead_a: assert property (
    st == wdc_pkg::ST_IDLE && go_q && !wg && ctrl.raw
    |=> st == wdc_pkg::ST_BODY)
    else $error("raw frame got framing");
  mode_frozen_a: assert property (
    busy && $past(busy) |-> $stable(ctrl))
    else $error("configuration changed mid-frame");

  wg_frame_c: cover property (
    wg && st == wdc_pkg::ST_DRAIN ##1 st == wdc_pkg::ST_IDLE);
  iso_frame_c: cover property (
    st == wdc_pkg::ST_TRAIL ##1 st == wdc_pkg::ST_DRAIN);
  raw_frame_c: cover property (
    ctrl.raw && st == wdc_pkg::ST_BODY ##1 st == wdc_pkg::ST_DRAIN);
  sep_sent_c: cover property (
    ld && st == wdc_pkg::ST_BODY && dg == wdc_pkg::DIG_SEP);
endmodule // wdc_top
`default_nettype wire

// *** tb/wdc_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// access controller: decodes bits, times low phases
// ************************************************
module wdc_ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_mode,
  input  wire logic        i_zero,
  input  wire logic        i_one,
  output logic             o_bit_stb,
  output logic             o_bit,
  output logic             o_len_stb,
  output logic      [15:0] o_len
);
  logic        z_q;
  logic        o_q;
  logic        a_q;
  logic [15:0] cnt;
  wire  logic  act = i_mode ? i_one : (i_zero & i_one);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      z_q       <= 1'b1;
      o_q       <= 1'b1;
      a_q       <= 1'b1;
      cnt       <= 16'h0000;
      o_bit_stb <= 1'b0;
      o_bit     <= 1'b0;
      o_len_stb <= 1'b0;
      o_len     <= 16'h0000;
    end else begin
      z_q       <= i_zero;
      o_q       <= i_one;
      a_q       <= act;
      o_bit_stb <= 1'b0;
      o_len_stb <= 1'b0;
      // sample on falling edges only
      if (i_mode && o_q && !i_one) begin
        o_bit_stb <= 1'b1;
        o_bit     <= ~i_zero;
      end else if (!i_mode && z_q && o_q && !(i_zero && i_one)) begin
        o_bit_stb <= 1'b1;
        o_bit     <= i_zero;
      end
      if (!act) begin
        cnt <= cnt + 16'h0001;
      end else if (!a_q) begin
        o_len_stb <= 1'b1;
        o_len     <= cnt;
        cnt       <= 16'h0000;
      end
    end
  end
endmodule // wdc_ctrl_model
`default_nettype wire

// *** tb/wdc_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdc_top_tb_top;
  localparam logic [15:0] PULSE  = 16'h0004;
  localparam logic [15:0] PERIOD = 16'h000c;
  localparam logic [15:0] THIRD  = 16'h0005;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, led_r, led_g, mode;
  logic        zero, one, red_on, green_on, b_stb, b_val, l_stb;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, r;
  logic [15:0] l_len, exp_low;
  logic [3:0]  dq[$];
  logic        eq[$];
  int          n_mismatch, comparisons;

  wdc_top #(.P_WG_PULSE(PULSE), .P_WG_PERIOD(PERIOD), .P_DC_THIRD(THIRD))
  dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_led_red(led_r),
    .i_led_green(led_g), .o_zero_bit_line(zero), .o_one_bit_line(one),
    .o_led_red_on(red_on), .o_led_green_on(green_on));

  wdc_ctrl_model ctl_u (.i_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
    .i_zero(zero), .i_one(one), .o_bit_stb(b_stb), .o_bit(b_val),
    .o_len_stb(l_stb), .o_len(l_len));

  // ************************************************
  // checking and closing
  // ************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ************************************************
  // bus master
  // ************************************************
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 64) begin
        n_mismatch++;
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_idle;
    int n;
    n  = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0) begin
      ahb(1'b0, wdc_pkg::A_STATUS, 32'h0);
      n++;
      if (n > 4000) begin
        n_mismatch++;
        tally_and_finish();
      end
    end
    check("bits left", 32'(eq.size()), 32'h0);
    check("idle lines", {30'h0, zero, one}, 32'h3);
  endtask

  // ************************************************
  // expected frames
  // ************************************************
  task automatic push_dig(input logic [3:0] d);
    for (int i = 0; i < 4; i++) eq.push_back(d[i]);
    eq.push_back(~^d);
  endtask

  task automatic build(input logic [31:0] d, input int len,
                       input logic [1:0] x, input logic raw);
    logic       run;
    logic [3:0] n;
    dq.delete();
    run = 1'b0;
    for (int k = len - 1; k >= 0; k--) begin
      n = d[4*k +: 4];
      if (raw || (n < 4'ha && x != 2'd2)) begin
        dq.push_back(n);
        run = 1'b0;
      end else if (x == 2'd2) begin
        dq.push_back(n / 4'ha);
        dq.push_back(n % 4'ha);
      end else if (x == 2'd1 && !run) begin
        dq.push_back(4'hd);
        run = 1'b1;
      end else if (x == 2'd3) begin
        dq.push_back(4'hd);
        dq.push_back(n - 4'ha);
      end
    end
  endtask

  task automatic run_dc(input logic [31:0] d, input int len,
                        input logic [1:0] x, input logic raw);
    logic [3:0] longitudinal_check_digit;
    build(d, len, x, raw);
    longitudinal_check_digit = 4'hb;
    if (!raw) begin
      repeat (16) eq.push_back(1'b0);
      push_dig(4'hb);
    end
    foreach (dq[i]) begin
      push_dig(dq[i]);
      longitudinal_check_digit ^= dq[i];
    end
    if (!raw) begin
      push_dig(4'hf);
      push_dig(longitudinal_check_digit);
      repeat (16) eq.push_back(1'b0);
    end
    mode <= 1'b1;
    ahb(1'b1, wdc_pkg::A_DATA, d);
    ahb(1'b1, wdc_pkg::A_CTRL, {18'h0, 6'(len), raw, 3'b000, x, 2'b11});
    wait_idle();
  endtask

  task automatic run_wg(input logic [31:0] d, input int len);
    for (int k = len - 1; k >= 0; k--) eq.push_back(d[k]);
    mode <= 1'b0;
    ahb(1'b1, wdc_pkg::A_DATA, d);
    ahb(1'b1, wdc_pkg::A_CTRL, {18'h0, 6'(len), 8'h01});
    // mode switch mid-frame must be ignored
    ahb(1'b1, wdc_pkg::A_CTRL, 32'h00000803);
    wait_idle();
  endtask

  // ************************************************
  // monitor
  // ************************************************
  always @(posedge clk) begin
    if (b_stb) begin
      if (eq.size() == 0) check("extra bit", 32'h1, 32'h0);
      else check("line bit", {31'h0, b_val}, {31'h0, eq.pop_front()});
    end
    if (l_stb) check("low time", {16'h0, l_len}, {16'h0, exp_low});
    if (rst_n && !mode && !zero && !one) check("both low", 32'h1, 32'h0);
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0; hsel = 1'b1; htrans = 2'b00; hsize = 3'b010;
    hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; led_r = 1'b1;
    led_g = 1'b1; mode = 1'b0; exp_low = PULSE;
    n_mismatch = 0; comparisons = 0;
    void'($urandom(32'h5a12691c));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, wdc_pkg::A_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    ahb(1'b0, wdc_pkg::A_PULSE, 32'h0);
    check("pulse reset", rd, {PERIOD, PULSE});
    ahb(1'b0, wdc_pkg::A_CLKOUT, 32'h0);
    check("clkout reset", rd, {16'h0, THIRD});
    ahb(1'b0, 8'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    hsize <= 3'b000;
    ahb(1'b1, wdc_pkg::A_CLKOUT, 32'h00000009);
    hsize <= 3'b010;
    ahb(1'b0, wdc_pkg::A_CLKOUT, 32'h0);
    check("byte write", rd, {16'h0, THIRD});
    run_wg($urandom, 32);
    ahb(1'b1, wdc_pkg::A_PULSE, 32'h000a0003);
    exp_low = 16'h0003;
    run_wg($urandom, 1);
    run_wg($urandom, 1 + $urandom % 32);
    ahb(1'b1, wdc_pkg::A_PULSE, 32'h0);
    exp_low = PULSE;
    run_wg($urandom, 4);
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      ahb(1'b1, wdc_pkg::A_CTRL, {30'h0, m[0], 1'b0});
      repeat (3) begin
        r = $urandom;
        led_r <= r[0];
        led_g <= r[1];
        repeat (4) @(posedge clk);
        check("led on", {30'h0, red_on, green_on},
              {30'h0, r[0] ^ m[0], r[1] ^ m[0]});
        ahb(1'b0, wdc_pkg::A_STATUS, 32'h0);
        check("led status", {30'h0, rd[2:1]},
              {30'h0, r[1] ^ m[0], r[0] ^ m[0]});
      end
    end
    exp_low = THIRD;
    for (int x = 0; x < 4; x++) run_dc(32'h7a126cf4, 8, x[1:0], 1'b0);
    run_dc($urandom, 1 + $urandom % 8, 2'd0, 1'b0);
    ahb(1'b1, wdc_pkg::A_CLKOUT, 32'h00000006);
    exp_low = 16'h0006;
    run_dc($urandom, 8, 2'd1, 1'b1);
    run_dc($urandom, 1 + $urandom % 8, 2'd0, 1'b1);
    ahb(1'b1, wdc_pkg::A_CLKOUT, 32'h0);
    exp_low = THIRD;
    run_dc($urandom, 2, 2'd3, 1'b0);
    tally_and_finish();
  end
endmodule // wdc_top_tb_top
`default_nettype wire
